//--- common/ppp_regs.svh
`ifndef PPP_REGS_SVH
`define PPP_REGS_SVH

// byte addresses of the register words
`define PPP_OFS_VAL_A 12'h000
`define PPP_OFS_VAL_B 12'h004
`define PPP_OFS_DIR_A 12'h008
`define PPP_OFS_DIR_B 12'h00C
`define PPP_OFS_OPT_A 12'h010
`define PPP_OFS_OPT_B 12'h014
`define PPP_OFS_ALT_A 12'h018
`define PPP_OFS_ALT_B 12'h01C
`define PPP_OFS_IRQ_CFG 12'h020
`define PPP_OFS_IRQ_STAT 12'h024
`define PPP_OFS_IRQ_MASK 12'h028

// irq_config_reg field positions
`define PPP_CFG_A_LEVEL_BIT 6
`define PPP_CFG_B_RISE_BIT 5
`define PPP_CFG_ALLOW_BIT 4

// status and mask field positions
`define PPP_STAT_A_BIT 0
`define PPP_STAT_B_BIT 1

// reset values
`define PPP_RST_BYTE 8'h00
// pins come out of reset as pulled-up inputs, so the idle pin level is high too
`define PPP_RST_PULL 8'hFF
`define PPP_RST_BIT 1'b0
`define PPP_RST_WORD 32'h0000_0000

`endif

//--- common/ppp_pkg.sv
package ppp_pkg;

  typedef enum logic [1:0] {
    TRIG_FALL,
    TRIG_RISE,
    TRIG_LOW
  } ppp_trig_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] opt;
    logic [7:0] alt;
  } ppp_pincfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
    logic [7:0] ana_sel;
  } ppp_pad_t;

  typedef struct packed {
    ppp_pad_t pad;
    logic [7:0] prev;
    logic req;
  } ppp_port_st_t;

  typedef struct packed {
    logic [1:0][7:0] latch;
    logic [1:0][7:0] dir;
    logic [1:0][7:0] opt;
    logic [1:0][7:0] alt;
    logic a_level;
    logic b_rise;
    logic allow;
    logic [1:0] stat;
    logic [1:0] mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } ppp_state_t;

endpackage

//--- verilog/ppp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppp_regs.svh"

module ppp_port
  import ppp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire ppp_pincfg_t cfg,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] alt_out,
  input wire ppp_trig_t trig,
  input wire logic allow,
  output var ppp_pad_t pad,
  output var logic req
);

  ppp_port_st_t st_reg;
  ppp_port_st_t st_next;
  logic [7:0] irq_en;
  logic [7:0] drive;
  logic [7:0] cond;

  always_comb
  begin
    st_next = st_reg;
    // interrupt variant: input, option 1, value 0
    irq_en = ~cfg.dir & cfg.opt & ~cfg.latch; // [R6]
    // alternate mode swaps the latch for the peripheral's signal
    drive = (cfg.alt & alt_out) | (~cfg.alt & cfg.latch); // [R16]
    st_next.pad.out = drive; // [R12]
    // open drain only switches the low side; a one floats
    st_next.pad.oe = cfg.dir & (cfg.opt | ~drive); // [R14] [R15]
    st_next.pad.pull_en = ~cfg.dir & ~cfg.latch; // [R5]
    st_next.pad.ana_sel = ~cfg.dir & cfg.opt & cfg.latch; // [R10]
    case (trig) // [R7]
      TRIG_FALL: cond = st_reg.prev & ~pin_in;
      TRIG_RISE: cond = ~st_reg.prev & pin_in;
      TRIG_LOW: cond = ~pin_in;
      default: cond = 8'h00;
    endcase
    st_next.req = allow & (|(irq_en & cond)); // [R9] [R18]
    st_next.prev = pin_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      // edge memory starts at the pulled-up level: no false edge after reset
      st_reg <= '{pad: '{out: `PPP_RST_BYTE, oe: `PPP_RST_BYTE, pull_en: `PPP_RST_PULL,
                         ana_sel: `PPP_RST_BYTE}, prev: `PPP_RST_PULL, req: `PPP_RST_BIT}; // [R3]
    else if (ce)
      st_reg <= st_next;
  end

  assign pad = st_reg.pad;
  assign req = st_reg.req;

endmodule

`default_nettype wire

//--- verilog/ppp_top.sv
// Notes on behaviour
// R1: two ports of eight pins, each pin configured on its own.
// R2: direction, value latch and option registers per port; bit x drives pin x.
// R3: reset clears every register: all pins pulled-up inputs, no interrupts.
// R4: direction zero makes an input; value reads return the live pin level.
// R5: input variants by option/value: pull-up, floating, pull-up with irq, analog.
// R6: any input pin joins the interrupt system in the irq input variant.
// R7: trigger chosen per port: falling edge, rising edge or low level.
// R8: port A falling or low level; port B falling or rising edge.
// R9: a pin event requests only in irq variant and with global allow set.
// R10: analog variant routes the pin toward the 8-bit converter.
// R11: software keeps at most one pin in the analog variant at once.
// R12: direction one makes an output; the latch is driven onto the pin.
// R13: value reads of output pins return the latch contents.
// R14: option one gives push-pull drive, option zero open drain.
// R15: latch zero drives low; one drives high or floats in open drain.
// R16: a pin carries port data or an on-chip peripheral's signal.
// R17: software configures the pin itself for any peripheral that uses it.
// R18: each port merges its enabled pin triggers into one request line.
`timescale 1ns/1ps
`default_nettype none
`include "ppp_regs.svh"

module ppp_top
  import ppp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pb_in,
  input wire logic [7:0] pa_alt_out,
  input wire logic [7:0] pb_alt_out,
  output var logic [7:0] pa_out,
  output var logic [7:0] pa_oe,
  output var logic [7:0] pa_pull_en,
  output var logic [7:0] pa_ana_sel,
  output var logic [7:0] pb_out,
  output var logic [7:0] pb_oe,
  output var logic [7:0] pb_pull_en,
  output var logic [7:0] pb_ana_sel,
  output var logic irq_req_a,
  output var logic irq_req_b,
  output var logic irq
);

  ppp_state_t st_reg;
  ppp_state_t st_next;
  logic [1:0][7:0] pin_in;
  logic [1:0][7:0] alt_out;
  ppp_pincfg_t [1:0] cfg;
  ppp_trig_t [1:0] trig;
  ppp_pad_t [1:0] pad;
  logic [1:0] req;
  logic access;
  logic known;
  logic do_write;
  logic [1:0] stat_clr;
  logic [31:0] rd_word;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // input pins show the pad, output pins the latch
  function automatic logic [7:0] rd_mix(input logic [7:0] dir, input logic [7:0] latch,
                                        input logic [7:0] pin);
    rd_mix = (dir & latch) | (~dir & pin); // [R4] [R13]
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  assign pin_in = {pb_in, pa_in};
  assign alt_out = {pb_alt_out, pa_alt_out};

  // port A level/edge select and port B edge select
  assign trig[0] = st_reg.a_level ? TRIG_LOW : TRIG_FALL; // [R8]
  assign trig[1] = st_reg.b_rise ? TRIG_RISE : TRIG_FALL; // [R8]

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_port
      assign cfg[g] = '{dir: st_reg.dir[g], latch: st_reg.latch[g], opt: st_reg.opt[g],
                        alt: st_reg.alt[g]};
      // one instance per port, every pin handled bitwise and alike
      ppp_port u_port ( // [R1] [R2]
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        .cfg(cfg[g]),
        .pin_in(pin_in[g]),
        .alt_out(alt_out[g]),
        .trig(trig[g]),
        .allow(st_reg.allow),
        .pad(pad[g]),
        .req(req[g])
      );
    end
  endgenerate

  always_comb
  begin
    access = psel & penable;
    known = hit(paddr, `PPP_OFS_VAL_A) | hit(paddr, `PPP_OFS_VAL_B) |
            hit(paddr, `PPP_OFS_DIR_A) | hit(paddr, `PPP_OFS_DIR_B) |
            hit(paddr, `PPP_OFS_OPT_A) | hit(paddr, `PPP_OFS_OPT_B) |
            hit(paddr, `PPP_OFS_ALT_A) | hit(paddr, `PPP_OFS_ALT_B) |
            hit(paddr, `PPP_OFS_IRQ_CFG) | hit(paddr, `PPP_OFS_IRQ_STAT) |
            hit(paddr, `PPP_OFS_IRQ_MASK);
    // writes land only on the completing edge, with byte lane 0 enabled
    do_write = access & st_reg.pready & pwrite & pstrb[0] & known;

    rd_word = `PPP_RST_WORD;
    if (hit(paddr, `PPP_OFS_VAL_A))
      rd_word = byte_word(rd_mix(st_reg.dir[0], st_reg.latch[0], pin_in[0]));
    else if (hit(paddr, `PPP_OFS_VAL_B))
      rd_word = byte_word(rd_mix(st_reg.dir[1], st_reg.latch[1], pin_in[1]));
    else if (hit(paddr, `PPP_OFS_DIR_A))
      rd_word = byte_word(st_reg.dir[0]);
    else if (hit(paddr, `PPP_OFS_DIR_B))
      rd_word = byte_word(st_reg.dir[1]);
    else if (hit(paddr, `PPP_OFS_OPT_A))
      rd_word = byte_word(st_reg.opt[0]);
    else if (hit(paddr, `PPP_OFS_OPT_B))
      rd_word = byte_word(st_reg.opt[1]);
    else if (hit(paddr, `PPP_OFS_ALT_A))
      rd_word = byte_word(st_reg.alt[0]);
    else if (hit(paddr, `PPP_OFS_ALT_B))
      rd_word = byte_word(st_reg.alt[1]);
    else if (hit(paddr, `PPP_OFS_IRQ_CFG))
    begin
      rd_word[`PPP_CFG_A_LEVEL_BIT] = st_reg.a_level;
      rd_word[`PPP_CFG_B_RISE_BIT] = st_reg.b_rise;
      rd_word[`PPP_CFG_ALLOW_BIT] = st_reg.allow;
    end
    else if (hit(paddr, `PPP_OFS_IRQ_STAT))
      rd_word[1:0] = st_reg.stat;
    else if (hit(paddr, `PPP_OFS_IRQ_MASK))
      rd_word[1:0] = st_reg.mask;

    st_next = st_reg;
    // one wait state: pready rises in the second access cycle
    st_next.pready = access & ~st_reg.pready;
    // error flag stands only beside pready, never lingers into idle cycles
    st_next.pslverr = 1'b0;
    if (access && !st_reg.pready)
    begin
      st_next.pslverr = ~known;
      st_next.prdata = pwrite ? `PPP_RST_WORD : rd_word;
    end

    stat_clr = 2'b00;
    if (do_write)
    begin
      // in input mode the latch still steers pull-up, irq and analog
      if (hit(paddr, `PPP_OFS_VAL_A))
        st_next.latch[0] = pwdata[7:0]; // [R5] [R12]
      if (hit(paddr, `PPP_OFS_VAL_B))
        st_next.latch[1] = pwdata[7:0]; // [R5] [R12]
      if (hit(paddr, `PPP_OFS_DIR_A))
        st_next.dir[0] = pwdata[7:0]; // [R4] [R12]
      if (hit(paddr, `PPP_OFS_DIR_B))
        st_next.dir[1] = pwdata[7:0]; // [R4] [R12]
      if (hit(paddr, `PPP_OFS_OPT_A))
        st_next.opt[0] = pwdata[7:0]; // [R14]
      if (hit(paddr, `PPP_OFS_OPT_B))
        st_next.opt[1] = pwdata[7:0]; // [R14]
      // no pin is claimed until software sets its alternate bit
      if (hit(paddr, `PPP_OFS_ALT_A))
        st_next.alt[0] = pwdata[7:0]; // [R16] [R17]
      if (hit(paddr, `PPP_OFS_ALT_B))
        st_next.alt[1] = pwdata[7:0]; // [R16] [R17]
      if (hit(paddr, `PPP_OFS_IRQ_CFG))
      begin
        st_next.a_level = pwdata[`PPP_CFG_A_LEVEL_BIT]; // [R8]
        st_next.b_rise = pwdata[`PPP_CFG_B_RISE_BIT]; // [R8]
        st_next.allow = pwdata[`PPP_CFG_ALLOW_BIT]; // [R9]
      end
      if (hit(paddr, `PPP_OFS_IRQ_STAT))
        stat_clr = pwdata[1:0];
      if (hit(paddr, `PPP_OFS_IRQ_MASK))
        st_next.mask = pwdata[1:0];
    end

    // set beats a clear in the same cycle; a held low level keeps setting
    st_next.stat = (st_reg.stat & ~stat_clr) | req; // [R18]
    st_next.irq = |(st_next.stat & st_next.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0; // [R3]
    else if (pce)
      st_reg <= st_next;
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign pa_out = pad[0].out;
  assign pa_oe = pad[0].oe;
  assign pa_pull_en = pad[0].pull_en;
  assign pa_ana_sel = pad[0].ana_sel; // [R10]
  assign pb_out = pad[1].out;
  assign pb_oe = pad[1].oe;
  assign pb_pull_en = pad[1].pull_en;
  assign pb_ana_sel = pad[1].ana_sel; // [R10]
  assign irq_req_a = req[0];
  assign irq_req_b = req[1];
  assign irq = st_reg.irq;

endmodule

`default_nettype wire

//--- testbench/ppp_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pull_en,
  input wire logic [7:0] pa_ana_sel,
  input wire logic [7:0] pb_pull_en,
  input wire logic [7:0] pb_ana_sel,
  input wire logic irq_req_a,
  input wire logic irq_req_b,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RST: assert property ($rose(presetn) |=> pa_pull_en == 8'hFF && pa_oe == 8'h00)
    else $error("pins wrong after reset");
  AST_PULL_ANA: assert property ((pa_pull_en & pa_ana_sel) == 8'h00)
    else $error("pull-up on analog pin");
  AST_OE_IN: assert property (((pa_pull_en | pa_ana_sel) & pa_oe) == 8'h00)
    else $error("input pin driven");
  AST_REQ_A: assert property (irq_req_a |-> pa_pull_en != 8'h00)
    else $error("port a request without irq pin");
  AST_REQ_B: assert property (irq_req_b |-> pb_pull_en != 8'h00)
    else $error("port b request without irq pin");
  // a mask write may also raise irq on an old status bit
  AST_IRQ_SRC: assert property ($rose(irq) |-> $past(irq_req_a || irq_req_b)
    || $past(pwrite && pready) || $past(pwrite && pready, 2))
    else $error("irq without request");
  AST_PREADY_T: assert property ((psel && !penable && pce) ##1 (penable && pce) ##1 pce
    |-> pready)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_PULSE: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_WIDTH: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read upper bits set");
  cover property ($rose(irq));
  cover property (pslverr);
  cover property (irq_req_b);
  cover property (pb_ana_sel != 8'h00);
endmodule
bind ppp_top ppp_top_props u_props (.pclk, .presetn, .pce, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .pa_oe, .pa_pull_en, .pa_ana_sel, .pb_pull_en, .pb_ana_sel,
  .irq_req_a, .irq_req_b, .irq);
`default_nettype wire

//--- testbench/ppp_pins.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_pins (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext_e,
  output var logic [7:0] pin
);
  // nothing holds a floating pin, so it wanders every clock
  logic [7:0] flt = 8'h5A;
  always @(posedge clk)
    flt <= ~flt;
  always_comb
    for (int i = 0; i < 8; i++)
      pin[i] = oe[i] ? out[i] : ext_e[i] ? 1'b0 : pull_en[i] ? 1'b1 : flt[i];
endmodule
`default_nettype wire

//--- testbench/parallel_pin_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppp_regs.svh"
module parallel_pin_port_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, irq, irq_req_a, irq_req_b;
  logic [7:0] pa_in, pb_in, pa_out, pa_oe, pa_pull_en, pa_ana_sel;
  logic [7:0] pb_out, pb_oe, pb_pull_en, pb_ana_sel;
  logic [7:0] alt_a = 8'h01, xa_e = 8'h00, xb_e = 8'h00;
  int fails = 0, n_tests = 0, cyc = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ppp_row_t;
  ppp_row_t rows [7] = '{'{`PPP_OFS_DIR_A, 32'hFF, 32'hFF}, '{`PPP_OFS_VAL_A, 32'h5A, 32'h5A},
    '{`PPP_OFS_OPT_A, 32'h0F, 32'h0F}, '{`PPP_OFS_ALT_A, 32'hFFFF_FF01, 32'h01},
    '{`PPP_OFS_DIR_B, 32'h0, 32'h0}, '{`PPP_OFS_VAL_B, 32'h0, 32'hFF},
    '{`PPP_OFS_IRQ_MASK, 32'h3, 32'h3}};
  initial forever #5 pclk = ~pclk;
  ppp_top dut (.pclk, .presetn, .pce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .pa_in, .pb_in, .pa_alt_out(alt_a),
    .pb_alt_out(8'h00), .pa_out, .pa_oe, .pa_pull_en, .pa_ana_sel, .pb_out, .pb_oe,
    .pb_pull_en, .pb_ana_sel, .irq_req_a, .irq_req_b, .irq);
  ppp_pins pin_a (.clk(pclk), .out(pa_out), .oe(pa_oe), .pull_en(pa_pull_en), .ext_e(xa_e),
    .pin(pa_in));
  ppp_pins pin_b (.clk(pclk), .out(pb_out), .oe(pb_oe), .pull_en(pb_pull_en), .ext_e(xb_e),
    .pin(pb_in));
  task automatic summarize();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after an edge; holds the request until pready is sampled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    cmp(rdat, exp);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp({pa_pull_en, pb_pull_en, pa_oe, pb_oe}, 32'hFFFF_0000);
    for (int i = 2; i < 11; i++)
      rd(12'(4 * i), 32'h0);
    rd(12'h030, 32'h0);
    cmp(rerr, 32'h1);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    cmp({pa_out, pa_oe}, 32'h5BAF);
    $display("register and drive test done");
    wr(`PPP_OFS_OPT_B, 32'h08);
    wr(`PPP_OFS_VAL_B, 32'h08);
    repeat (2) @(posedge pclk);
    cmp({pb_ana_sel, pb_pull_en}, 32'h08F7);
    $display("analog test done");
    wr(`PPP_OFS_OPT_A, 32'h01);
    wr(`PPP_OFS_VAL_A, 32'h00);
    wr(`PPP_OFS_DIR_A, 32'h00);
    wr(`PPP_OFS_IRQ_CFG, 32'h10);
    xa_e <= 8'h01;
    repeat (4) @(posedge pclk);
    cmp(irq, 32'h1);
    rd(`PPP_OFS_IRQ_STAT, 32'h1);
    wr(`PPP_OFS_IRQ_STAT, 32'h1);
    rd(`PPP_OFS_IRQ_STAT, 32'h0);
    cmp(irq, 32'h0);
    wr(`PPP_OFS_IRQ_CFG, 32'h50);
    wr(`PPP_OFS_IRQ_STAT, 32'h1);
    rd(`PPP_OFS_IRQ_STAT, 32'h1);
    xa_e <= 8'h00;
    repeat (3) @(posedge pclk);
    wr(`PPP_OFS_IRQ_STAT, 32'h3);
    wr(`PPP_OFS_IRQ_CFG, 32'h00);
    xa_e <= 8'h01;
    repeat (4) @(posedge pclk);
    rd(`PPP_OFS_IRQ_STAT, 32'h0);
    $display("port a irq test done");
    wr(`PPP_OFS_IRQ_CFG, 32'h30);
    wr(`PPP_OFS_OPT_B, 32'h02);
    wr(`PPP_OFS_VAL_B, 32'h00);
    xb_e <= 8'h02;
    repeat (4) @(posedge pclk);
    rd(`PPP_OFS_IRQ_STAT, 32'h0);
    xb_e <= 8'h00;
    repeat (4) @(posedge pclk);
    rd(`PPP_OFS_IRQ_STAT, 32'h2);
    cmp(irq, 32'h1);
    wr(`PPP_OFS_IRQ_STAT, 32'h2);
    wr(`PPP_OFS_IRQ_MASK, 32'h1);
    xb_e <= 8'h02;
    repeat (4) @(posedge pclk);
    xb_e <= 8'h00;
    repeat (4) @(posedge pclk);
    rd(`PPP_OFS_IRQ_STAT, 32'h2);
    cmp(irq, 32'h0);
    $display("port b irq test done");
    wr(`PPP_OFS_DIR_A, 32'hFF);
    wr(`PPP_OFS_IRQ_MASK, 32'h3);
    cmp(irq, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp({pa_pull_en, pb_pull_en, pa_oe, pb_oe}, 32'hFFFF_0000);
    cmp(irq, 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(`PPP_OFS_DIR_A, 32'h0);
    rd(`PPP_OFS_IRQ_MASK, 32'h0);
    rd(`PPP_OFS_IRQ_STAT, 32'h0);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
`default_nettype wire
